// File: serial_adc_host_interface.sv
// Purpose: device-side serial interface of a two-channel sampling converter
// Assumes: converter core answers each sample strobe with one word on conv_*
// Notes:   pins are resynchronised; dout lags the shift clock by a few core cycles
`timescale 1ns/10ps
`include "adc_cfg.svh"
module serial_adc_host_interface (
  input  wire logic           core_clk,
  input  wire logic           resetn,
  input  wire logic           shift_clk,
  input  wire logic           select_sleep_n,
  output logic                dout,
  output logic                dout_oe,
  output logic                sleep,
  output logic                sample_strobe,
  output adc_pkg::chan_e      sample_channel,
  input  wire adc_pkg::data_t conv_data,
  input  wire logic           conv_valid,
  output logic                conv_ready
);
  import adc_pkg::*;

  adc_link_if lnk ();

  logic        sel_s1_r;
  logic        sel_s2_r;
  logic        sel_prev_r;
  logic        sclk_s1_r;
  logic        sclk_s2_r;
  logic        sclk_prev_r;
  logic        bit_s1_r;
  logic        bit_s2_r;
  logic        act_s1_r;
  logic        act_s2_r;
  logic        sel_fall;
  logic        sel_rise;
  logic        sclk_fall;
  conv_state_e state_r;
  clk_mode_e   mode_r;
  chan_e       chan_r;
  logic        first_done_r;
  logic [4:0]  edge_cnt_r;
  logic [4:0]  sample_edge;
  logic [12:0] conv_cnt_r;
  logic        conv_done;
  logic        eoc_r;
  word_t       tx_word_r;
  logic        word_ready_r;
  logic        dout_r;
  logic        dout_oe_r;
  logic        sleep_r;
  logic        strobe_r;
  chan_e       sample_chan_r;
  data_t       fifo_data;
  logic        fifo_valid;
  logic        fifo_pop;

  result_fifo #(
    .W     (`DATA_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .resetn    (resetn),
    .in_data   (conv_data),
    .in_valid  (conv_valid),
    .in_ready  (conv_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  shift_out u_shift (
    .shift_clk      (shift_clk),
    .resetn         (resetn),
    .select_sleep_n (select_sleep_n),
    .lnk            (lnk.link)
  );

  assign lnk.tx_word    = tx_word_r;
  assign lnk.word_ready = word_ready_r;

  // pins and link-domain levels, two flops each before use
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sel_s1_r    <= 1'b1;
      sel_s2_r    <= 1'b1;
      sel_prev_r  <= 1'b1;
      sclk_s1_r   <= 1'b0;
      sclk_s2_r   <= 1'b0;
      sclk_prev_r <= 1'b0;
      bit_s1_r    <= 1'b0;
      bit_s2_r    <= 1'b0;
      act_s1_r    <= 1'b0;
      act_s2_r    <= 1'b0;
    end else begin
      sel_s1_r    <= select_sleep_n;
      sel_s2_r    <= sel_s1_r;
      sel_prev_r  <= sel_s2_r;
      sclk_s1_r   <= shift_clk;
      sclk_s2_r   <= sclk_s1_r;
      sclk_prev_r <= sclk_s2_r;
      bit_s1_r    <= lnk.link_bit;
      bit_s2_r    <= bit_s1_r;
      act_s1_r    <= lnk.link_active;
      act_s2_r    <= act_s1_r;
    end
  end

  assign sel_fall    = sel_prev_r && !sel_s2_r;
  assign sel_rise    = !sel_prev_r && sel_s2_r;
  assign sclk_fall   = sclk_prev_r && !sclk_s2_r && !sel_s2_r;
  assign sample_edge = (mode_r == MODE_INT) ? `INT_SAMPLE_EDGE : `EXT_SAMPLE_EDGE; // RULE8
  assign conv_done   = (mode_r == MODE_EXT) || (conv_cnt_r >= 13'(`INT_CONV_CYC));
  assign fifo_pop    = (state_r == ST_CONV) && conv_done && fifo_valid && !sel_s2_r;

  // both levels pass the same two flops, so the setup at the pin is kept
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_r <= MODE_EXT;
    end else if (sel_fall) begin
      mode_r <= sclk_s2_r ? MODE_INT : MODE_EXT; // RULE6
    end
  end

  // channel order survives shutdown; only reset returns it to the first input
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      chan_r       <= chan_e'(`CHAN_RESET);
      first_done_r <= 1'b0;
    end else if (sel_fall) begin
      first_done_r <= 1'b1;
      if (first_done_r) begin
        chan_r <= (chan_r == first_input_channel) ? second_input_channel : first_input_channel; // RULE9
      end
    end
  end

  // counts falling shift edges inside one select frame
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      edge_cnt_r <= 5'h00;
    end else if (sel_fall) begin
      edge_cnt_r <= 5'h00;
    end else if (sclk_fall && edge_cnt_r != `FRAME_EDGES) begin
      edge_cnt_r <= edge_cnt_r + 5'h01; // RULE5
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_SLEEP;
    end else if (sel_s2_r) begin
      state_r <= ST_SLEEP; // RULE1
    end else begin
      case (state_r)
        ST_SLEEP: begin
          if (sel_fall) begin
            state_r <= ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (sclk_fall && edge_cnt_r == sample_edge - 5'h01) begin
            state_r <= ST_CONV; // RULE8
          end
        end
        ST_CONV: begin
          if (fifo_pop) begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_r <= ST_DONE;
        end
        default: begin
          state_r <= ST_SLEEP;
        end
      endcase
    end
  end

  // sample request to the converter core, one cycle wide
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      strobe_r      <= 1'b0;
      sample_chan_r <= first_input_channel;
    end else begin
      strobe_r <= (state_r == ST_ACQ) && !sel_s2_r && sclk_fall && edge_cnt_r == sample_edge - 5'h01; // RULE8
      if (state_r == ST_ACQ) begin
        sample_chan_r <= chan_r; // RULE9
      end
    end
  end

  // stands in for the on-chip oscillator: a fixed conversion time in core cycles
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      conv_cnt_r <= 13'h0000;
    end else if (state_r != ST_CONV) begin
      conv_cnt_r <= 13'h0000;
    end else if (conv_cnt_r != 13'h1fff) begin
      conv_cnt_r <= conv_cnt_r + 13'h0001;
    end
  end

  // word held stable for the whole frame, dropped when select rises
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_word_r    <= '0;
      word_ready_r <= 1'b0;
    end else if (sel_s2_r) begin
      word_ready_r <= 1'b0;
    end else if (fifo_pop) begin
      tx_word_r    <= {chan_r, fifo_data};
      word_ready_r <= 1'b1;
    end
  end

  // end-of-conversion flag; cleared once the shifter takes over the pin
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      eoc_r <= 1'b0;
    end else if (sel_s2_r || act_s2_r) begin
      eoc_r <= 1'b0;
    end else if (fifo_pop && mode_r == MODE_INT) begin
      eoc_r <= 1'b1; // RULE7
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dout_r    <= 1'b0;
      dout_oe_r <= 1'b0;
      sleep_r   <= 1'b1;
    end else begin
      dout_r    <= act_s2_r ? bit_s2_r : eoc_r; // RULE3 RULE7
      dout_oe_r <= !sel_s2_r; // RULE2
      sleep_r   <= sel_s2_r; // RULE1
    end
  end

  assign dout           = dout_r;
  assign dout_oe        = dout_oe_r;
  assign sleep          = sleep_r;
  assign sample_strobe  = strobe_r;
  assign sample_channel = sample_chan_r;

  // helper: core cycles since the last falling shift edge
  logic [3:0] since_fall_r;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      since_fall_r <= 4'hf;
    end else if (sclk_fall) begin
      since_fall_r <= 4'h0;
    end else if (since_fall_r != 4'hf) begin
      since_fall_r <= since_fall_r + 4'h1;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  a_sleep_on_high: assert property ($rose(sel_s2_r) |=> sleep_r && state_r == ST_SLEEP) // RULE1
    else $error("device not in shutdown while deselected");
  a_oe_follows_sel: assert property (sel_s2_r ##1 sel_s2_r |=> !dout_oe_r && !dout_r) // RULE2
    else $error("result output driven while deselected");
  a_oe_on_select: assert property (sel_fall |=> dout_oe_r [*2]) // RULE2
    else $error("result output not enabled after select");
  a_dout_after_fall: assert property ((act_s2_r && $past(act_s2_r) && $changed(dout_r)) |-> since_fall_r < 4'h8) // RULE3
    else $error("result output changed away from a falling edge");
  a_edge_saturate: assert property ((edge_cnt_r == `FRAME_EDGES && sclk_fall && !sel_fall) |=> edge_cnt_r == `FRAME_EDGES) // RULE5
    else $error("frame edge count passed its limit");
  a_mode_pick: assert property (sel_fall |=> mode_r == ($past(sclk_s2_r) ? MODE_INT : MODE_EXT)) // RULE6
    else $error("clock mode not taken from clock level at select");
  a_eoc_time: assert property ($rose(eoc_r) |-> mode_r == MODE_INT && $past(conv_cnt_r) >= 13'(`INT_CONV_CYC)) // RULE7
    else $error("end of conversion too early or in external mode");
  a_eoc_high: assert property ((eoc_r && !act_s2_r && !sel_s2_r) |=> dout_r) // RULE7
    else $error("end of conversion not shown on the output");
  a_ext_second: assert property ((strobe_r && mode_r == MODE_EXT) |-> edge_cnt_r == `EXT_SAMPLE_EDGE) // RULE8
    else $error("external sample not on second falling edge");
  a_chan_first: assert property ((sel_fall && !first_done_r) |=> chan_r == first_input_channel) // RULE9
    else $error("first conversion not on the first channel");
  a_chan_toggle: assert property ((sel_fall && first_done_r) |=> chan_r != $past(chan_r)) // RULE9
    else $error("channel did not alternate");
  a_strobe_single: assert property (strobe_r |=> !strobe_r) // RULE8
    else $error("sample request wider than one cycle");
  a_int_first: assert property ((strobe_r && mode_r == MODE_INT) |-> edge_cnt_r == `INT_SAMPLE_EDGE) // RULE6
    else $error("internal sample not on first falling edge");
  a_oe_release: assert property ($rose(sel_s2_r) |=> !dout_oe_r) // RULE2
    else $error("result output not released after deselect");
  a_eoc_ext_never: assert property ((mode_r == MODE_EXT) |-> !eoc_r) // RULE7
    else $error("end of conversion flagged in external mode");
  a_dout_quiet: assert property ((!act_s2_r && !eoc_r) |=> !dout_r) // RULE3
    else $error("result output moved without a shifted bit");
  a_wake_on_low: assert property (!sel_s2_r |=> !sleep_r) // RULE1
    else $error("device still in shutdown while selected");

  c_ext_sample: cover property (strobe_r && mode_r == MODE_EXT);
  c_int_eoc: cover property ($rose(eoc_r) ##[1:1000] $rose(act_s2_r));
  c_fifo_full: cover property (!conv_ready);
  c_chan_second: cover property (strobe_r && sample_chan_r == second_input_channel);
  c_int_sample: cover property (strobe_r && mode_r == MODE_INT);
endmodule

// File: adc_cfg.svh
// Purpose: constants of the serial converter interface
// Assumes: core clock 250 MHz
// Notes:   times kept in ns, cycle counts derived
// Contract
// [RULE1] select low selects the converter; select high is low-power shutdown.
// [RULE2] result output driven after select falls, undriven while deselected.
// [RULE3] result output changes only on shift clock falling edges.
// [RULE4] host keeps shift clock 0.1-2.17 MHz external, up to 5 MHz internal.
// [RULE5] external conversion cycle spans 16 shift clocks, 50% duty clock.
// [RULE6] clock level at select fall picks internal (high) or external (low) mode.
// [RULE7] internal mode: after conversion, output driven high as end of conversion.
// [RULE8] external mode: sample taken on second falling clock edge after select.
// [RULE9] first channel after power-on, then channels alternate per select cycle.
// [RULE10] host waits wake-up delay and divides its clock to meet mode limits.
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH
`define DATA_W         10
`define WORD_W         11
`define FIFO_DEPTH     32
`define EXT_SAMPLE_EDGE 5'h02
`define INT_SAMPLE_EDGE 5'h01
`define FRAME_EDGES    5'h10
`define CORE_CLK_NS    4
`define INT_CONV_NS    5000
`define INT_CONV_CYC   ((`INT_CONV_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define CHAN_RESET     1'b0
`endif

// File: adc_pkg.sv
// Purpose: shared types of the serial converter interface
// Assumes: widths from adc_cfg.svh
// Notes:   one-hot state codes
`include "adc_cfg.svh"
package adc_pkg;
  typedef enum logic [3:0] {
    ST_SLEEP = 4'h1,
    ST_ACQ   = 4'h2,
    ST_CONV  = 4'h4,
    ST_DONE  = 4'h8
  } conv_state_e;
  typedef enum logic {
    MODE_EXT = 1'b0,
    MODE_INT = 1'b1
  } clk_mode_e;
  typedef enum logic {
    first_input_channel  = 1'b0,
    second_input_channel = 1'b1
  } chan_e;
  typedef logic [`DATA_W-1:0] data_t;
  typedef logic [`WORD_W-1:0] word_t;
endpackage

// File: adc_link_if.sv
// Purpose: carrier between core and shift-clock logic
// Assumes: tx_word stable while word_ready is high
// Notes:   every signal but tx_word crosses domains through two flops at the reader
`timescale 1ns/10ps
interface adc_link_if;
  import adc_pkg::*;
  word_t tx_word;
  logic  word_ready;
  logic  link_bit;
  logic  link_active;
  modport core (output tx_word, output word_ready, input link_bit, input link_active);
  modport link (input tx_word, input word_ready, output link_bit, output link_active);
endinterface

// File: result_fifo.sv
// Purpose: buffer of converted words between converter and serial side
// Assumes: single clock, power-of-two depth
// Notes:   flags are registered so they can leave the top directly
`timescale 1ns/10ps
module result_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 32
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          room_r;
  logic          empty_r;
  logic          push;
  logic          pop;

  // ready leaves the top, so it is a flop of its own rather than an inverted full flag
  assign push      = in_valid && room_r;
  assign pop       = out_ready && !empty_r;
  assign in_ready  = room_r;
  assign out_valid = !empty_r;
  assign out_data  = mem[rd_ptr_r];

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
      room_r   <= 1'b1;
      empty_r  <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      cnt_r   <= cnt_nxt;
      room_r  <= (cnt_nxt != (AW+1)'(DEPTH));
      empty_r <= (cnt_nxt == '0);
    end
  end
endmodule

// File: shift_out.sv
// Purpose: serial shifter running on the host's shift clock
// Assumes: shift clock falls only while select is low
// Notes:   held in reset by select high, so a frame always starts clean
`timescale 1ns/10ps
`include "adc_cfg.svh"
module shift_out (
  input  wire logic shift_clk,
  input  wire logic resetn,
  input  wire logic select_sleep_n,
  adc_link_if.link  lnk
);
  import adc_pkg::*;
  logic       link_rst_n;
  logic       rdy_s1_r;
  logic       rdy_s2_r;
  word_t      shreg_r;
  logic [3:0] left_r;

  // deselect ends the frame asynchronously: no clock edge follows it
  assign link_rst_n = resetn && !select_sleep_n;

  always_ff @(negedge shift_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rdy_s1_r <= 1'b0;
      rdy_s2_r <= 1'b0;
    end else begin
      rdy_s1_r <= lnk.word_ready;
      rdy_s2_r <= rdy_s1_r;
    end
  end

  // all state moves on falling edges only
  always_ff @(negedge shift_clk or negedge link_rst_n) begin // RULE3
    if (!link_rst_n) begin
      lnk.link_active <= 1'b0;
      lnk.link_bit    <= 1'b0;
      shreg_r         <= '0;
      left_r          <= '0;
    end else if (!lnk.link_active && rdy_s2_r) begin
      lnk.link_active <= 1'b1;
      lnk.link_bit    <= lnk.tx_word[`WORD_W-1]; // RULE3
      shreg_r         <= {lnk.tx_word[`WORD_W-2:0], 1'b0};
      left_r          <= 4'(`WORD_W - 1);
    end else if (lnk.link_active && left_r != 4'h0) begin
      lnk.link_bit <= shreg_r[`WORD_W-1]; // RULE3
      shreg_r      <= {shreg_r[`WORD_W-2:0], 1'b0};
      left_r       <= left_r - 4'h1;
    end else if (lnk.link_active) begin
      lnk.link_bit <= 1'b0;
    end
  end
endmodule

// File: host_model.sv
// Purpose: host side of the link, drives select and the shift clock
// Assumes: shift clock stands low outside frames, except when set high ahead of an internal-mode select fall
// Notes:   a released line reads as the inverse of the last driven bit
`timescale 1ns/10ps
module host_model #(
  parameter realtime wakeup_delay = 2500.0
) (
  output logic      select_sleep_n,
  output logic      shift_clk,
  input  wire logic dout,
  input  wire logic dout_oe
);
  logic        last_r;
  logic        ext_frame;
  logic [31:0] rx;
  realtime     t_fall;
  int          bad_edge;
  wire         line_lvl = dout_oe ? dout : ~last_r;

  initial begin
    select_sleep_n = 1'b1;
    shift_clk = 1'b0;
    last_r = 1'b0;
    ext_frame = 1'b0;
    rx = 32'h0;
    t_fall = 0.0;
    bad_edge = 0;
  end

  always @(negedge shift_clk) t_fall = $realtime;

  always @(dout) begin
    if (dout_oe === 1'b1) last_r = dout;
    // end of conversion is not tied to a clock edge, so only external frames are watched
    if (ext_frame && dout_oe === 1'b1 && $realtime - t_fall > 40.0) bad_edge++;
  end

  // clock level is set well ahead of the select fall and held after it
  task automatic start(input logic clk_lvl);
    shift_clk = clk_lvl;
    // fractional delays keep link edges off the core clock edges
    #100.37;
    ext_frame = ~clk_lvl;
    select_sleep_n = 1'b0;
    #(wakeup_delay);
  endtask

  task automatic stop();
    #100.37;
    ext_frame = 1'b0;
    select_sleep_n = 1'b1;
    shift_clk = 1'b0;
    #100.37;
  endtask

  task automatic drop_clk();
    shift_clk = 1'b0;
  endtask

  task automatic pulses(input int n, input realtime half);
    for (int i = 0; i < n; i++) begin
      shift_clk = 1'b1;
      rx = {rx[30:0], line_lvl};
      #(half);
      shift_clk = 1'b0;
      #(half);
    end
  endtask
endmodule

// File: serial_adc_host_interface_tb.sv
// Purpose: self-checking bench of the device-side serial converter interface
// Assumes: host model paces the link; a small converter model answers strobes
// Notes:   shift clock kept inside its legal ranges, hence slower than a bench could run it
`timescale 1ns/10ps
module serial_adc_host_interface_tb;
  import adc_pkg::*;
  // odd fractions keep the link clock unrelated in phase to core_clk
  localparam realtime EXT_HALF = 241.37;
  localparam realtime INT_HALF = 101.37;
  logic  core_clk;
  logic  resetn;
  logic  shift_clk;
  logic  select_sleep_n;
  logic  dout;
  logic  dout_oe;
  logic  sleep;
  logic  sample_strobe;
  chan_e sample_channel;
  data_t conv_data;
  logic  conv_valid;
  logic  conv_ready;
  logic  cvt_en;
  logic  fill_mode;
  int    err_count;
  int    checked;
  int    falls;
  int    strobes;
  int    pushes;

  serial_adc_host_interface u_dut (
    .core_clk      (core_clk),
    .resetn        (resetn),
    .shift_clk     (shift_clk),
    .select_sleep_n(select_sleep_n),
    .dout          (dout),
    .dout_oe       (dout_oe),
    .sleep         (sleep),
    .sample_strobe (sample_strobe),
    .sample_channel(sample_channel),
    .conv_data     (conv_data),
    .conv_valid    (conv_valid),
    .conv_ready    (conv_ready)
  );

  host_model u_host (
    .select_sleep_n(select_sleep_n),
    .shift_clk     (shift_clk),
    .dout          (dout),
    .dout_oe       (dout_oe)
  );

  always #2 core_clk = ~core_clk;
  always @(negedge select_sleep_n) falls++;

  function automatic data_t val_of(input logic ch);
    return ch ? 10'h1b3 : 10'h2a5;
  endfunction

  function automatic logic [31:0] x1(input logic b);
    return {31'h0, b};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // a word offered is held until taken, as the stream contract asks
  always @(posedge core_clk) begin
    if (conv_valid === 1'b1 && conv_ready === 1'b1) pushes++;
    if (sample_strobe === 1'b1) begin
      strobes++;
      check("sample_channel", x1(sample_channel), x1(~falls[0]));
    end
    if (fill_mode) begin
      conv_data <= 10'h0f0;
      conv_valid <= 1'b1;
    end else if (sample_strobe === 1'b1 && cvt_en) begin
      conv_data <= val_of(sample_channel);
      conv_valid <= 1'b1;
    end else if (conv_valid && conv_ready) conv_valid <= 1'b0;
  end

  // word must sit at some offset with only zeros after it
  task automatic check_word(input logic ch);
    word_t w;
    logic  hit;
    w = {ch, val_of(ch)};
    hit = 1'b0;
    for (int k = 0; k <= 4; k++)
      if (u_host.rx[k +: 11] === w && (u_host.rx & ((32'h1 << k) - 32'h1)) === 32'h0) hit = 1'b1;
    check("serial_word", x1(hit), 32'h1);
  endtask

  task automatic t_ext();
    logic ch;
    int   s0;
    ch = falls[0];
    s0 = strobes;
    u_host.rx = 32'h0;
    u_host.bad_edge = 0;
    u_host.start(1'b0);
    check("dout_oe_on", x1(dout_oe), 32'h1);
    check("sleep_off", x1(sleep), 32'h0);
    u_host.pulses(1, EXT_HALF);
    check("early_strobe", strobes - s0, 32'h0);
    u_host.pulses(1, EXT_HALF);
    check("strobe", strobes - s0, 32'h1);
    u_host.pulses(14, EXT_HALF);
    check_word(ch);
    check("late_change", u_host.bad_edge, 32'h0);
    u_host.stop();
    check("dout_oe_off", x1(dout_oe), 32'h0);
    check("sleep_on", x1(sleep), 32'h1);
    $display("test external frame done");
  endtask

  task automatic t_int();
    logic ch;
    int   s0;
    ch = falls[0];
    s0 = strobes;
    u_host.rx = 32'h0;
    u_host.start(1'b1);
    u_host.drop_clk();
    cyc(10);
    check("int_strobe", strobes - s0, 32'h1);
    cyc(1090);
    check("dout_busy", x1(dout), 32'h0);
    cyc(300);
    check("dout_eoc", x1(dout & dout_oe), 32'h1);
    u_host.pulses(16, INT_HALF);
    check_word(ch);
    u_host.stop();
    $display("test internal frame done");
  endtask

  task automatic t_repeat();
    u_host.start(1'b0);
    u_host.stop();
    t_ext();
    $display("test channel repeat done");
  endtask

  task automatic t_fifo();
    int p0;
    int n;
    cvt_en = 1'b0;
    p0 = pushes;
    @(posedge core_clk);
    fill_mode <= 1'b1;
    n = 0;
    while (conv_ready !== 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
    cyc(50);
    fill_mode <= 1'b0;
    check("fifo_words", pushes - p0, 32'd32);
    check("fifo_full", x1(conv_ready), 32'h0);
    for (int i = 0; i < 33; i++) begin
      u_host.start(1'b0);
      u_host.pulses(2, EXT_HALF);
      u_host.stop();
    end
    check("fifo_taken", pushes - p0, 32'd33);
    check("fifo_ready", x1(conv_ready), 32'h1);
    cvt_en = 1'b1;
    t_ext();
    $display("test fifo fill and drain done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #300000;
    check("watchdog", 32'h1, 32'h0);
    tally_and_finish();
  end

  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    conv_data = 10'h000;
    conv_valid = 1'b0;
    cvt_en = 1'b1;
    fill_mode = 1'b0;
    err_count = 0;
    checked = 0;
    falls = 0;
    strobes = 0;
    pushes = 0;
    cyc(9);
    check("sleep_rst", x1(sleep), 32'h1);
    check("dout_oe_rst", x1(dout_oe), 32'h0);
    @(posedge core_clk);
    resetn <= 1'b1;
    cyc(2);
    t_ext();
    t_int();
    t_repeat();
    t_fifo();
    tally_and_finish();
  end
endmodule
